// File: common/alu_status_flags_map.vh
// Purpose: register map, field positions, opcodes and reset values
//          of the ALU status flag block.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes:   included by its bare name; definitions only.
`ifndef ALU_STATUS_FLAGS_MAP_VH
`define ALU_STATUS_FLAGS_MAP_VH

// ****************************************************
// register byte offsets
// ****************************************************
`define OFS_FLAGS     8'h00
`define OFS_ACC       8'h04
`define OFS_FILE      8'h08
`define OFS_CMD       8'h0c
`define OFS_RESULT    8'h10

// ****************************************************
// flag bit positions and reset values
// ****************************************************
`define FLG_CARRY     0
`define FLG_HALF      1
`define FLG_ZERO      2
`define FLG_OVF       3
`define FLG_NEG       4
`define FLAGS_RESET   5'h00
`define DATA_RESET    8'h00
`define CMD_RESET     24'h000000

// ****************************************************
// command word fields
// ****************************************************
`define CMD_OP        3:0
`define CMD_TO_FILE   4
`define CMD_FILE_FLG  5
`define CMD_BIT       10:8
`define CMD_LIT       23:16
`define CMD_WIDTH     24

// ****************************************************
// operation codes
// ****************************************************
`define OP_ADD_FILE   4'h0
`define OP_ADD_LIT    4'h1
`define OP_SUB_FILE   4'h2
`define OP_SUB_LIT    4'h3
`define OP_ROT_LEFT   4'h4
`define OP_ROT_RIGHT  4'h5
`define OP_AND        4'h6
`define OP_IOR        4'h7
`define OP_XOR        4'h8
`define OP_CLEAR      4'h9
`define OP_BIT_CLR    4'ha
`define OP_BIT_SET    4'hb
`define OP_SWAP       4'hc
`define OP_MOVE       4'hd
`define OP_STORE      4'he

`endif

// File: logic/alu_status_flags.v
// Purpose: arithmetic status flags of an 8-bit core with a small
//          ALU, accumulator and one file operand, all over APB.
// Assumes: APB master keeps the request until pready is seen.
// Notes:   one wait state per transfer; a command write executes.
`timescale 1ns/100ps
`default_nettype none
`include "alu_status_flags_map.vh"

module alu_status_flags #(
   parameter ADDR_W = 8
) (
   // clock and reset
   input  wire              ref_clk,
   input  wire              reset_n,
   // apb slave
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [ADDR_W-1:0] paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output reg               pready,
   output reg               pslverr,
   // flag state to the core
   output reg  [4:0]        aluFlags
);

   // ****************************************************
   // state
   // ****************************************************
   reg  [4:0]            flags_r;
   reg  [7:0]            acc_r;
   reg  [7:0]            file_r;
   reg  [`CMD_WIDTH-1:0] cmd_r;
   reg  [7:0]            res_r;
   reg  [4:0]            flagsNxt;
   reg  [7:0]            accNxt;
   reg  [7:0]            fileNxt;
   reg  [`CMD_WIDTH-1:0] cmdNxt;
   reg  [7:0]            resNxt;

   // ****************************************************
   // bus decode
   // ****************************************************
   wire                  accessPh;
   wire                  takeEdge;
   wire                  wrTake;
   reg                   hit;
   reg  [31:0]           rdMux;

   assign accessPh = psel & penable;
   assign takeEdge = accessPh & pready;
   assign wrTake   = takeEdge & pwrite & ~pslverr;

   always @* begin
      hit   = 1'b1;
      rdMux = 32'h00000000;
      if (paddr == `OFS_FLAGS) begin
         // unimplemented upper bits read zero
         rdMux = {27'h0, flags_r};
      end else if (paddr == `OFS_ACC) begin
         rdMux = {24'h000000, acc_r};
      end else if (paddr == `OFS_FILE) begin
         rdMux = {24'h000000, file_r};
      end else if (paddr == `OFS_CMD) begin
         rdMux = {8'h00, cmd_r};
      end else if (paddr == `OFS_RESULT) begin
         rdMux = {24'h000000, res_r};
      end else begin
         hit = 1'b0;
      end
   end

   // ****************************************************
   // operand selection
   // ****************************************************
   wire [3:0] op;
   wire       toFile;
   wire       fileIsFlags;
   wire [2:0] bitSel;
   wire [7:0] literal;
   wire       litOp;
   reg  [7:0] srcA;
   wire [7:0] srcB;

   assign op          = pwdata[`CMD_OP];
   assign toFile      = pwdata[`CMD_TO_FILE];
   assign fileIsFlags = pwdata[`CMD_FILE_FLG];
   assign bitSel      = pwdata[`CMD_BIT];
   assign literal     = pwdata[`CMD_LIT];
   assign litOp       = (op == `OP_ADD_LIT) | (op == `OP_SUB_LIT);
   assign srcB        = acc_r;

   always @* begin
      if (litOp) begin
         srcA = literal;
      end else if (fileIsFlags) begin
         srcA = {3'b000, flags_r};
      end else begin
         srcA = file_r;
      end
   end

   // ****************************************************
   // adder
   // ****************************************************
   wire       isSub;
   wire [7:0] addend;
   wire       carryIn;
   wire [8:0] sumFull;
   wire [4:0] sumLow;
   wire [7:0] sumRes;
   wire       sumOvf;

   assign isSub   = (op == `OP_SUB_FILE) | (op == `OP_SUB_LIT);
   assign addend  = isSub ? ~srcB : srcB;
   assign carryIn = isSub;
   assign sumFull = {1'b0, srcA} + {1'b0, addend} + {8'h00, carryIn};
   assign sumLow  = {1'b0, srcA[3:0]} + {1'b0, addend[3:0]}
                    + {4'h0, carryIn};
   assign sumRes  = sumFull[7:0];
   assign sumOvf  = (srcA[7] == addend[7]) & (sumRes[7] != srcA[7]);

   // ****************************************************
   // alu result and flag candidates
   // ****************************************************
   reg  [7:0] aluRes;
   reg  [4:0] updMask;
   reg  [4:0] newVals;
   reg  [7:0] bitMask;

   always @* begin
      bitMask = 8'h01 << bitSel;
      aluRes  = 8'h00;
      updMask = 5'h00;
      newVals = 5'h00;
      case (op)
         `OP_ADD_FILE, `OP_ADD_LIT, `OP_SUB_FILE, `OP_SUB_LIT: begin
            aluRes  = sumRes;
            updMask = 5'h1f;
            // half carry out of bit 3
            newVals[`FLG_HALF]  = sumLow[4];
            newVals[`FLG_CARRY] = sumFull[8];
            newVals[`FLG_OVF]   = sumOvf;
         end
         `OP_ROT_LEFT: begin
            aluRes  = {srcA[6:0], flags_r[`FLG_CARRY]};
            updMask = 5'h17;
            newVals[`FLG_CARRY] = srcA[7];
            newVals[`FLG_HALF]  = srcA[3];
         end
         `OP_ROT_RIGHT: begin
            aluRes  = {flags_r[`FLG_CARRY], srcA[7:1]};
            updMask = 5'h17;
            newVals[`FLG_CARRY] = srcA[0];
            newVals[`FLG_HALF]  = srcA[4];
         end
         `OP_AND: begin
            aluRes  = srcA & srcB;
            updMask = 5'h14;
         end
         `OP_IOR: begin
            aluRes  = srcA | srcB;
            updMask = 5'h14;
         end
         `OP_XOR: begin
            aluRes  = srcA ^ srcB;
            updMask = 5'h14;
         end
         `OP_CLEAR: begin
            aluRes  = 8'h00;
            updMask = 5'h04;
         end
         `OP_BIT_CLR: begin
            aluRes = srcA & ~bitMask;
         end
         `OP_BIT_SET: begin
            aluRes = srcA | bitMask;
         end
         `OP_SWAP: begin
            aluRes = {srcA[3:0], srcA[7:4]};
         end
         `OP_MOVE: begin
            aluRes = srcA;
         end
         `OP_STORE: begin
            aluRes = srcB;
         end
         default: begin
            aluRes = srcA;
         end
      endcase
      newVals[`FLG_NEG]  = aluRes[7];
      newVals[`FLG_ZERO] = (aluRes == 8'h00);
   end

   // ****************************************************
   // next state of the register file
   // ****************************************************
   reg [4:0] flagsAlu;
   reg       writeToFile;

   always @* begin
      flagsNxt    = flags_r;
      accNxt      = acc_r;
      fileNxt     = file_r;
      cmdNxt      = cmd_r;
      resNxt      = res_r;
      flagsAlu    = (flags_r & ~updMask) | (newVals & updMask);
      // store always lands in the file; literal ops in the accumulator
      writeToFile = ((op == `OP_STORE) | toFile) & ~litOp;
      if (wrTake) begin
         if (paddr == `OFS_FLAGS) begin
            flagsNxt = pwdata[4:0];
         end else if (paddr == `OFS_ACC) begin
            accNxt = pwdata[7:0];
         end else if (paddr == `OFS_FILE) begin
            fileNxt = pwdata[7:0];
         end else if (paddr == `OFS_CMD) begin
            cmdNxt   = pwdata[`CMD_WIDTH-1:0];
            resNxt   = aluRes;
            flagsNxt = flagsAlu;
            if (writeToFile & fileIsFlags) begin
               if (updMask == 5'h00) begin
                  flagsNxt = aluRes[4:0];
               end else begin
                  flagsNxt = flagsAlu;
               end
            end else if (writeToFile) begin
               fileNxt = aluRes;
            end else begin
               accNxt = aluRes;
            end
         end
      end
   end

   // ****************************************************
   // registers
   // ****************************************************
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         flags_r <= `FLAGS_RESET;
         acc_r   <= `DATA_RESET;
         file_r  <= `DATA_RESET;
         cmd_r   <= `CMD_RESET;
         res_r   <= `DATA_RESET;
      end else begin
         flags_r <= flagsNxt;
         acc_r   <= accNxt;
         file_r  <= fileNxt;
         cmd_r   <= cmdNxt;
         res_r   <= resNxt;
      end
   end

   // ****************************************************
   // bus answer
   // ****************************************************
   // one wait state keeps prdata and pslverr straight from flops
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else if (accessPh & ~pready) begin
         pready  <= 1'b1;
         pslverr <= ~hit | (pwrite & (paddr == `OFS_RESULT));
         prdata  <= pwrite ? 32'h00000000 : rdMux;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // flag port mirrors the register after each update
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         aluFlags <= `FLAGS_RESET;
      end else begin
         aluFlags <= flagsNxt;
      end
   end

endmodule // alu_status_flags

`default_nettype wire

// File: tb/alu_status_flags_monitor.sv
// Purpose: bus and flag checks on the status flag block
// Assumes: one wait state per APB transfer
// Notes:   bound from the bench top
`timescale 1ns/100ps
`default_nettype none
`include "alu_status_flags_map.vh"
module alu_status_flags_monitor #(
   parameter ADDR_W = 8
) (
   // clock and reset
   input wire logic              ref_clk,
   input wire logic              reset_n,
   // apb
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // flags
   input wire logic [4:0]        aluFlags
);
   // ****************
   // checks
   // ****************
   wire       wrDone = psel && penable && pready && pwrite;
   wire       rdDone = psel && penable && pready && !pwrite;
   wire       cmdWr  = wrDone && paddr == `OFS_CMD;
   wire [3:0] opc    = pwdata[`CMD_OP];
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready not after one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_flags_write: assert property (wrDone && paddr == `OFS_FLAGS |=> aluFlags == $past(pwdata[4:0]))
      else $error("flag write not taken");
   a_flags_read: assert property (rdDone && paddr == `OFS_FLAGS |-> prdata == {27'h0, aluFlags})
      else $error("flag read wrong");
   a_flags_quiet: assert property (!$stable(aluFlags) |-> $past(wrDone && (paddr == `OFS_FLAGS || cmdWr)))
      else $error("flags changed without write");
   a_keep_ops: assert property (cmdWr && opc >= `OP_BIT_CLR && opc <= `OP_STORE && !pwdata[`CMD_FILE_FLG]
      |=> $stable(aluFlags)) else $error("flags touched by neutral op");
   a_clear_zero: assert property (cmdWr && opc == `OP_CLEAR |=> aluFlags == ($past(aluFlags) | 5'h04))
      else $error("clear op flags wrong");
   c_clear_flags: cover property (cmdWr && opc == `OP_CLEAR && pwdata[`CMD_FILE_FLG]);
   c_error: cover property (pslverr);
   c_rotate: cover property (cmdWr && opc == `OP_ROT_RIGHT);
endmodule // alu_status_flags_monitor
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: self-checking bench of the status flag block
// Assumes: APB master, fixed xorshift seed
// Notes:   expected flags from a bench model
`timescale 1ns/100ps
`default_nettype none
`include "alu_status_flags_map.vh"
module tb_top;
   logic        ref_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire  [4:0]  aluFlags;
   logic [31:0] seed = 32'h4a9a;
   logic [31:0] rdat;
   logic        rerr;
   logic [4:0]  fm;
   logic [7:0]  a, b, l;
   logic [3:0]  o;
   logic [12:0] e;
   int          err_count = 0;
   int          n_tests = 0;
   alu_status_flags dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .aluFlags(aluFlags));
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   // ****************
   // helpers
   // ****************
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [12:0] alu(input logic [3:0] op, input logic [7:0] x0, y0, li, input logic [4:0] f);
      logic [7:0] x, y, r;
      logic       c, h, v;
      logic [8:0] s;
      c = (op == `OP_SUB_FILE || op == `OP_SUB_LIT);
      x = (op == `OP_ADD_LIT || op == `OP_SUB_LIT) ? li : x0;
      y = c ? ~y0 : y0;
      s = x + y + c;
      h = ({1'b0, x[3:0]} + y[3:0] + c) > 5'h0f;
      v = (x[7] == y[7]) && (s[7] != x[7]);
      r = s[7:0];
      if (op <= `OP_SUB_LIT) f = {r[7], v, r == 8'h00, h, s[8]};
      else if (op == `OP_ROT_LEFT) begin
         r = {x0[6:0], f[0]};
         f = {r[7], f[3], r == 8'h00, x0[3], x0[7]};
      end else if (op == `OP_ROT_RIGHT) begin
         r = {f[0], x0[7:1]};
         f = {r[7], f[3], r == 8'h00, x0[4], x0[0]};
      end else begin
         r = (op == `OP_AND) ? x0 & y0 : (op == `OP_IOR) ? x0 | y0 : x0 ^ y0;
         f = {r[7], f[3], r == 8'h00, f[1:0]};
      end
      return {r, f};
   endfunction
   task summarize;
      $display("tests %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // master holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) err_count++;
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task chkrd(input logic [7:0] ad, input logic [31:0] exp);
      apb(1'b0, ad, 32'h0);
      chk(rdat, exp);
   endtask
   task cmd(input logic [3:0] op, input logic tf, fl, input logic [2:0] bi, input logic [7:0] li);
      apb(1'b1, `OFS_CMD, {8'h00, li, 5'h00, bi, 2'b00, fl, tf, op});
   endtask
   // ****************
   // main sequence
   // ****************
   initial begin
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 5; i++) chkrd(i * 4, 32'h0);
      apb(1'b1, `OFS_FLAGS, 32'hffffffff);
      chkrd(`OFS_FLAGS, 32'h1f);
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      chk(rdat, 32'h0);
      apb(1'b1, `OFS_RESULT, 32'h55);
      chk({31'h0, rerr}, 32'h1);
      apb(1'b1, `OFS_FLAGS, 32'h0a);
      cmd(`OP_CLEAR, 1'b1, 1'b1, 3'h0, 8'h00);
      chkrd(`OFS_FLAGS, 32'h0e);
      apb(1'b1, `OFS_FLAGS, 32'h10);
      apb(1'b1, `OFS_ACC, 32'hf0);
      cmd(`OP_ADD_FILE, 1'b1, 1'b1, 3'h0, 8'h00);
      e = alu(`OP_ADD_FILE, 8'h10, 8'hf0, 8'h00, 5'h10);
      chkrd(`OFS_FLAGS, e[4:0]);
      for (int k = `OP_BIT_CLR; k <= `OP_STORE; k++) begin
         apb(1'b1, `OFS_FLAGS, 32'h15);
         cmd(k, 1'b0, 1'b0, 3'h3, 8'h00);
         chkrd(`OFS_FLAGS, 32'h15);
      end
      // swap into the file register keeps flags
      apb(1'b1, `OFS_FILE, 32'h3c);
      cmd(`OP_SWAP, 1'b1, 1'b0, 3'h0, 8'h00);
      chkrd(`OFS_FILE, 32'hc3);
      chkrd(`OFS_FLAGS, 32'h15);
      apb(1'b1, `OFS_FLAGS, 32'h0);
      cmd(`OP_BIT_SET, 1'b1, 1'b1, 3'h3, 8'h00);
      chkrd(`OFS_FLAGS, 32'h08);
      fm = 5'h08;
      for (int i = 0; i < 40; i++) begin
         a = rnd();
         b = rnd();
         l = rnd();
         o = rnd() % 9;
         if (i == 0) {a, b, o} = {8'h7f, 8'h01, `OP_ADD_FILE};
         if (i == 1) {a, b, o} = {8'h00, 8'h01, `OP_SUB_FILE};
         apb(1'b1, `OFS_FILE, {24'h0, a});
         apb(1'b1, `OFS_ACC, {24'h0, b});
         cmd(o, 1'b0, 1'b0, 3'h0, l);
         e = alu(o, a, b, l, fm);
         fm = e[4:0];
         chkrd(`OFS_RESULT, e[12:5]);
         chkrd(`OFS_ACC, e[12:5]);
         chkrd(`OFS_FLAGS, fm);
         chk(aluFlags, fm);
      end
      summarize();
   end
   // run should end well before this
   initial begin
      #100000;
      err_count++;
      summarize();
   end
endmodule // tb_top
bind alu_status_flags alu_status_flags_monitor #(.ADDR_W(ADDR_W)) mon (.ref_clk(ref_clk), .reset_n(reset_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .aluFlags(aluFlags));
`default_nettype wire
